// ==== verilog/nand_host_defs.vh ====
// Command codes, address layout and timing counts for the NAND host controller
`ifndef NAND_HOST_DEFS_VH
`define NAND_HOST_DEFS_VH
// ==========================================================================
// Command codes
`define CMD_READ_A 8'h00
`define CMD_READ_B 8'h01
`define CMD_READ_SPARE 8'h50
`define CMD_READ_IDENTIFICATION_CMD 8'h90
`define CMD_RESET 8'hFF
`define CMD_PROG_SETUP 8'h80
`define CMD_PROG_CONFIRM 8'h10
`define CMD_COPY_CONFIRM 8'h8A
`define CMD_LOCK 8'h2A
`define CMD_UNLOCK_LO 8'h23
`define CMD_UNLOCK_HI 8'h24
`define CMD_LOCK_FREEZE 8'h2C
`define CMD_LOCK_STATUS 8'h7A
`define CMD_ERASE_SETUP 8'h60
`define CMD_ERASE_CONFIRM 8'hD0
`define CMD_STATUS 8'h70
// ==========================================================================
// Operation codes on the user port
`define OP_READ 4'h0
`define OP_READ_SPARE 4'h1
`define OP_READ_IDENTIFICATION_CMD 4'h2
`define OP_RESET 4'h3
`define OP_PROGRAM 4'h4
`define OP_COPYBACK 4'h5
`define OP_ERASE 4'h6
`define OP_STATUS 4'h7
`define OP_LOCK 4'h8
`define OP_UNLOCK 4'h9
`define OP_LOCK_FREEZE 4'hA
`define OP_LOCK_STATUS 4'hB
// ==========================================================================
// Array geometry
`define PAGE_COLS_X8 10'd528
`define PAGE_COLS_X16 10'd264
`define SPARE_COL_X8 10'd512
`define SPARE_COL_X16 10'd256
`define PAGE_COUNT 17'd65536
`define BLOCK_COUNT 12'd2048
// ==========================================================================
// Strobe timing: each strobe phase lasts at least this many ns
`define STROBE_PHASE_NS 30
`define CLK_PERIOD_NS 10
`define STROBE_PHASE_CYC ((`STROBE_PHASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ==== verilog/nand_host.v ====
// Host-side NAND page controller: drives strobes, latches and I/O to the flash
`timescale 1ns/100ps
`include "nand_host_defs.vh"

// Contract
// [RULE1] 65536 pages, 528 bytes or 264 words
// [RULE2] Spare columns 512-527 or 256-263
// [RULE3] Page data passes through page register
// [RULE4] Read/program pages, erase whole blocks
// [RULE5] 2048 erasable blocks per device
// [RULE6] No bit erase; block is smallest
// [RULE7] Commands, addresses on low eight lines
// [RULE8] Write strobe low pulse, rising latch
// [RULE9] Command latch or address latch select
// [RULE10] Reset, read, status single cycle
// [RULE11] Program 80h/10h, copy-back 00h/8Ah
// [RULE12] Erase 60h then D0h
// [RULE13] Address: column, low row, high row
// [RULE14] Read/program take exactly three addresses
// [RULE15] Erase takes two row addresses
// [RULE16] 50h second read, 90h identification
// [RULE17] Lock, unlock, freeze, lock status codes
// [RULE18] Only reset and status while busy
// [RULE19] Host sends only defined codes
// [RULE20] 01h never sent to wide part
// [RULE21] Extra one-time-programmable block exists
// [RULE22] 00h/01h select page register half
// [RULE23] Extra address cycles ignored
// [RULE24] Ready/busy low during operations
// [RULE25] Read strobe fall advances column
module nand_host #(
    parameter WIDE = 0
) (
    input wire mclk,
    input wire reset_n,
    input wire opValid,
    output wire opReady,
    input wire [3:0] opCode,
    input wire [7:0] opColumn,
    input wire [15:0] opRow,
    input wire [9:0] opCount,
    input wire opHalf,
    input wire [15:0] wrData,
    input wire wrValid,
    output wire wrReady,
    output reg [15:0] rdData_q,
    output reg rdValid_q,
    output reg opDone_q,
    output reg opError_q,
    output reg busyView_q,
    output reg chipSelect_n_q,
    output reg cmdLatch_q,
    output reg addrLatch_q,
    output reg write_strobe_n_q,
    output reg read_strobe_n_q,
    output reg [15:0] ioOut_q,
    output reg ioOe_q,
    input wire [15:0] ioIn,
    input wire readyBusy_n
);

// ==========================================================================
// States and sequencing
localparam ST_IDLE = 4'd0;
localparam ST_CMD1 = 4'd1;
localparam ST_ADDR = 4'd2;
localparam ST_WDATA = 4'd3;
localparam ST_CMD2 = 4'd4;
localparam ST_WAITB = 4'd5;
localparam ST_RDATA = 4'd6;
localparam ST_DONE = 4'd7;
localparam ST_BUSYW = 4'd8;
localparam integer PHASE_FULL = `STROBE_PHASE_CYC;
localparam [7:0] PHASE = PHASE_FULL[7:0];

reg [3:0] state_q, op_q;
reg [7:0] col_q, timer_q;
reg [15:0] row_q;
reg [9:0] count_q;
reg [1:0] addrIdx_q;
reg half_q, strobeLow_q, busyPipe_q;

// First command byte for each operation
function [7:0] firstCmd;
    input [3:0] op;
    input half;
    begin
        case (op)
            `OP_READ: firstCmd = (half && !WIDE) ? `CMD_READ_B : `CMD_READ_A; // see [RULE20] see [RULE22]
            `OP_READ_SPARE: firstCmd = `CMD_READ_SPARE; // see [RULE16]
            `OP_READ_IDENTIFICATION_CMD: firstCmd = `CMD_READ_IDENTIFICATION_CMD; // see [RULE16]
            `OP_RESET: firstCmd = `CMD_RESET; // see [RULE10]
            `OP_PROGRAM: firstCmd = `CMD_PROG_SETUP; // see [RULE11]
            `OP_COPYBACK: firstCmd = `CMD_READ_A; // see [RULE11]
            `OP_ERASE: firstCmd = `CMD_ERASE_SETUP; // see [RULE12]
            `OP_STATUS: firstCmd = `CMD_STATUS; // see [RULE10]
            `OP_LOCK: firstCmd = `CMD_LOCK; // see [RULE17]
            `OP_UNLOCK: firstCmd = `CMD_UNLOCK_LO; // see [RULE17]
            `OP_LOCK_FREEZE: firstCmd = `CMD_LOCK_FREEZE; // see [RULE17]
            default: firstCmd = `CMD_LOCK_STATUS; // see [RULE17]
        endcase
    end
endfunction

// Confirm byte for two-cycle operations
function [7:0] secondCmd;
    input [3:0] op;
    begin
        case (op)
            `OP_PROGRAM: secondCmd = `CMD_PROG_CONFIRM;
            `OP_COPYBACK: secondCmd = `CMD_COPY_CONFIRM;
            `OP_ERASE: secondCmd = `CMD_ERASE_CONFIRM;
            default: secondCmd = `CMD_UNLOCK_HI;
        endcase
    end
endfunction

// Address cycles the operation needs; ID read takes one, unlock two rows
function [1:0] addrCycles;
    input [3:0] op;
    begin
        case (op)
            `OP_READ, `OP_READ_SPARE, `OP_PROGRAM, `OP_COPYBACK: addrCycles = 2'd3; // see [RULE14]
            `OP_ERASE, `OP_UNLOCK, `OP_LOCK_STATUS: addrCycles = 2'd2; // see [RULE15]
            `OP_READ_IDENTIFICATION_CMD: addrCycles = 2'd1;
            default: addrCycles = 2'd0; // see [RULE10]
        endcase
    end
endfunction

// Undefined operation codes are refused
wire opLegal = (opCode <= `OP_LOCK_STATUS); // see [RULE19]
// While the part is busy only reset and status go out
wire busyOk = busyPipe_q || (opCode == `OP_RESET) || (opCode == `OP_STATUS); // see [RULE18]
assign opReady = (state_q == ST_IDLE);
wire tick = (timer_q == 8'd0);
assign wrReady = (state_q == ST_WDATA) && tick && !strobeLow_q;
wire isTwo = (op_q == `OP_PROGRAM) || (op_q == `OP_COPYBACK) || (op_q == `OP_ERASE) || (op_q == `OP_UNLOCK);
wire isRead = (op_q == `OP_READ) || (op_q == `OP_READ_SPARE) || (op_q == `OP_READ_IDENTIFICATION_CMD)
    || (op_q == `OP_STATUS) || (op_q == `OP_LOCK_STATUS);
wire waitsBusy = (op_q == `OP_READ) || (op_q == `OP_READ_SPARE) || isTwo || (op_q == `OP_RESET);

// Address byte for the current cycle: column, low row, high row
wire [7:0] addrByte = (addrCycles(op_q) == 2'd3) ? ((addrIdx_q == 2'd0) ? col_q :
    (addrIdx_q == 2'd1) ? row_q[7:0] : row_q[15:8]) :
    ((addrIdx_q == 2'd0) ? ((op_q == `OP_READ_IDENTIFICATION_CMD) ? col_q : row_q[7:0]) : row_q[15:8]); // see [RULE13]

// ==========================================================================
// Main sequencer: every bus cycle is a low phase then a high phase
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        state_q <= ST_IDLE;
        op_q <= 4'h0;
        col_q <= 8'h00;
        row_q <= 16'h0000;
        count_q <= 10'h000;
        half_q <= 1'b0;
        addrIdx_q <= 2'd0;
        timer_q <= 8'h00;
        strobeLow_q <= 1'b0;
        busyPipe_q <= 1'b1;
        rdData_q <= 16'h0000;
        rdValid_q <= 1'b0;
        opDone_q <= 1'b0;
        opError_q <= 1'b0;
        busyView_q <= 1'b0;
        chipSelect_n_q <= 1'b1;
        cmdLatch_q <= 1'b0;
        addrLatch_q <= 1'b0;
        write_strobe_n_q <= 1'b1;
        read_strobe_n_q <= 1'b1;
        ioOut_q <= 16'h0000;
        ioOe_q <= 1'b0;
    end else begin
        busyPipe_q <= readyBusy_n; // see [RULE24]
        busyView_q <= !busyPipe_q;
        rdValid_q <= 1'b0;
        opDone_q <= 1'b0;
        opError_q <= 1'b0;
        if (!tick)
            timer_q <= timer_q - 8'd1;
        case (state_q)
            ST_IDLE: begin
                chipSelect_n_q <= 1'b1;
                if (opValid) begin
                    if (!opLegal || !busyOk) begin
                        opError_q <= 1'b1;
                    end else begin
                        op_q <= opCode;
                        col_q <= opColumn;
                        row_q <= opRow;
                        count_q <= opCount;
                        half_q <= opHalf;
                        addrIdx_q <= 2'd0;
                        chipSelect_n_q <= 1'b0;
                        timer_q <= PHASE;
                        state_q <= ST_CMD1;
                    end
                end
            end
            ST_CMD1, ST_CMD2, ST_ADDR: begin
                if (tick) begin
                    if (!strobeLow_q) begin
                        // Commands and addresses use the low byte only
                        cmdLatch_q <= (state_q != ST_ADDR); // see [RULE9]
                        addrLatch_q <= (state_q == ST_ADDR); // see [RULE9]
                        ioOut_q <= {8'h00, (state_q == ST_CMD1) ? firstCmd(op_q, half_q) :
                            (state_q == ST_CMD2) ? secondCmd(op_q) : addrByte}; // see [RULE7]
                        ioOe_q <= 1'b1;
                        write_strobe_n_q <= 1'b0; // see [RULE8]
                        strobeLow_q <= 1'b1;
                        timer_q <= PHASE;
                    end else begin
                        write_strobe_n_q <= 1'b1; // see [RULE8]
                        strobeLow_q <= 1'b0;
                        timer_q <= PHASE;
                        if (state_q == ST_CMD2) begin
                            state_q <= ST_WAITB; // see [RULE11]
                            addrIdx_q <= 2'd0; // Marks the confirm as sent
                        end else if (state_q == ST_ADDR && addrIdx_q + 2'd1 < addrCycles(op_q)) begin
                            addrIdx_q <= addrIdx_q + 2'd1;
                        end else if (state_q == ST_CMD1 && addrCycles(op_q) != 2'd0) begin
                            state_q <= ST_ADDR;
                        end else if (op_q == `OP_PROGRAM) begin
                            state_q <= (count_q == 10'h000) ? ST_CMD2 : ST_WDATA;
                        end else if (isTwo && op_q != `OP_COPYBACK) begin // Copy-back confirms after page load
                            state_q <= ST_CMD2;
                        end else
                            state_q <= waitsBusy ? ST_WAITB : (isRead ? ST_RDATA : ST_DONE);
                    end
                end
            end
            ST_WDATA: begin
                cmdLatch_q <= 1'b0;
                addrLatch_q <= 1'b0;
                if (tick) begin
                    if (!strobeLow_q) begin
                        if (wrValid) begin
                            ioOut_q <= WIDE ? wrData : {8'h00, wrData[7:0]}; // see [RULE7]
                            ioOe_q <= 1'b1;
                            write_strobe_n_q <= 1'b0;
                            strobeLow_q <= 1'b1;
                            timer_q <= PHASE;
                        end
                    end else begin
                        write_strobe_n_q <= 1'b1;
                        strobeLow_q <= 1'b0;
                        timer_q <= PHASE;
                        count_q <= count_q - 10'd1;
                        if (count_q == 10'd1)
                            state_q <= ST_CMD2;
                    end
                end
            end
            ST_WAITB: begin
                // Give the part a phase to pull busy low, then wait for release
                cmdLatch_q <= 1'b0;
                addrLatch_q <= 1'b0;
                ioOe_q <= 1'b0;
                if (tick)
                    state_q <= ST_BUSYW;
            end
            ST_BUSYW: begin
                if (busyPipe_q) begin // see [RULE24] see [RULE18]
                    timer_q <= PHASE;
                    state_q <= (op_q == `OP_COPYBACK && addrIdx_q != 2'd0) ? ST_CMD2 : (isRead ? ST_RDATA : ST_DONE);
                end
            end
            ST_RDATA: begin
                cmdLatch_q <= 1'b0;
                addrLatch_q <= 1'b0;
                ioOe_q <= 1'b0;
                if (count_q == 10'h000) begin
                    state_q <= ST_DONE;
                end else if (tick) begin
                    if (!strobeLow_q) begin
                        // Each falling read strobe presents the next column
                        read_strobe_n_q <= 1'b0; // see [RULE25]
                        strobeLow_q <= 1'b1;
                        timer_q <= PHASE;
                    end else begin
                        rdData_q <= WIDE ? ioIn : {8'h00, ioIn[7:0]};
                        rdValid_q <= 1'b1;
                        read_strobe_n_q <= 1'b1;
                        strobeLow_q <= 1'b0;
                        timer_q <= PHASE;
                        count_q <= count_q - 10'd1;
                    end
                end
            end
            ST_DONE: begin
                chipSelect_n_q <= 1'b1;
                opDone_q <= 1'b1;
                state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
        endcase
    end
end
endmodule // nand_host

// ==== test/nand_host_properties.sv ====
// Port-level properties of the NAND host controller
`timescale 1ns/100ps
`include "nand_host_defs.vh"
module nand_host_properties (
    input wire mclk,
    input wire reset_n,
    input wire opValid,
    input wire opReady,
    input wire [3:0] opCode,
    input wire opError_q,
    input wire busyView_q,
    input wire chipSelect_n_q,
    input wire cmdLatch_q,
    input wire addrLatch_q,
    input wire write_strobe_n_q,
    input wire read_strobe_n_q,
    input wire [15:0] ioOut_q,
    input wire ioOe_q,
    input wire readyBusy_n
);
    // ========================================
    // Strobe shape and bus cycle content
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence weHeld; (!write_strobe_n_q)[*4]; endsequence
    sequence weRelease; write_strobe_n_q; endsequence
    weShape_a: assert property ($fell(write_strobe_n_q) |-> weHeld ##1 weRelease)
        else $error("write strobe low phase wrong length");
    holdWrite_a: assert property (!write_strobe_n_q && !$past(write_strobe_n_q) |->
        $stable(ioOut_q) && $stable(cmdLatch_q) && $stable(addrLatch_q) && ioOe_q) else $error("bus moved under strobe");
    latchExcl_a: assert property (!(cmdLatch_q && addrLatch_q)) else $error("both latches high");
    strobeCs_a: assert property (!write_strobe_n_q || !read_strobe_n_q |-> !chipSelect_n_q)
        else $error("strobe without select");
    upperLow_a: assert property ((cmdLatch_q || addrLatch_q) && !write_strobe_n_q |-> ioOut_q[15:8] == 8'h00)
        else $error("upper lines busy in command cycle");
    readOeOff_a: assert property (!read_strobe_n_q |-> !ioOe_q && write_strobe_n_q && !cmdLatch_q)
        else $error("drive during read strobe");
    cmdCodes_a: assert property (cmdLatch_q && !write_strobe_n_q |-> ioOut_q[7:0] inside {8'h00, 8'h01,
        8'h50, 8'h90, 8'hFF, 8'h80, 8'h10, 8'h8A, 8'h2A, 8'h23, 8'h24, 8'h2C, 8'h7A, 8'h60, 8'hD0, 8'h70})
        else $error("undefined command code");
    // ========================================
    // Refusals and busy tracking
    refuseCode_a: assert property (opValid && opReady && opCode > 4'hB |=> opError_q && chipSelect_n_q)
        else $error("bad code not refused");
    refuseBusy_a: assert property (opValid && opReady && busyView_q && opCode != `OP_RESET
        && opCode != `OP_STATUS |=> opError_q) else $error("busy request not refused");
    busyMirror_a: assert property ($fell(readyBusy_n) |-> ##[1:4] busyView_q) else $error("busy not seen");
endmodule // nand_host_properties

bind nand_host nand_host_properties props (.mclk(mclk), .reset_n(reset_n), .opValid(opValid), .opReady(opReady),
    .opCode(opCode), .opError_q(opError_q), .busyView_q(busyView_q), .chipSelect_n_q(chipSelect_n_q),
    .cmdLatch_q(cmdLatch_q), .addrLatch_q(addrLatch_q), .write_strobe_n_q(write_strobe_n_q),
    .read_strobe_n_q(read_strobe_n_q), .ioOut_q(ioOut_q), .ioOe_q(ioOe_q), .readyBusy_n(readyBusy_n));

// ==== test/nand_dev_model.sv ====
// Behavioural flash part answering the host controller
`timescale 1ns/100ps
module nand_dev_model (
    input wire mclk,
    input wire chipSelect_n,
    input wire cmdLatch,
    input wire addrLatch,
    input wire writeStrobe_n,
    input wire read_strobe_n,
    input wire [15:0] ioBus,
    input wire holdBusy,
    input wire [7:0] busyLen,
    output wire [15:0] ioDrive,
    output wire readyBusy_n
);
    logic [7:0] cmdQ[$], addrQ[$], datQ[$];
    reg [7:0] lastCmd = 8'hFF;
    reg [9:0] colCnt = 10'h000;
    reg [15:0] drive = 16'h5a5a;
    integer addrNum = 0;
    integer busyCnt = 0;
    wire [7:0] pat = colCnt[7:0] ^ {colCnt[8], 7'h00};
    // Open drain line, pulled up unless an operation or holdBusy holds it
    assign readyBusy_n = (busyCnt == 0) && !holdBusy;
    assign ioDrive = drive;
    // ========================================
    // Bus cycles latched on the rising write strobe
    always @(posedge writeStrobe_n) begin
        if (!chipSelect_n && cmdLatch) begin
            cmdQ.push_back(ioBus[7:0]);
            lastCmd = ioBus[7:0];
            addrNum = 0;
            if (lastCmd == 8'h10 || lastCmd == 8'h8A || lastCmd == 8'hD0) busyCnt = busyLen;
        end else if (!chipSelect_n && addrLatch) begin
            addrQ.push_back(ioBus[7:0]);
            addrNum = addrNum + 1;
            if (addrNum == 1) colCnt = {1'b0, lastCmd == 8'h01, ioBus[7:0]} + (lastCmd == 8'h50 ? 10'h200 : 10'h000);
            if (addrNum == 3 && (lastCmd == 8'h00 || lastCmd == 8'h01 || lastCmd == 8'h50)) busyCnt = busyLen;
        end else if (!chipSelect_n) begin
            datQ.push_back(ioBus[7:0]);
        end
    end
    // Falling read strobe shows the next column; released lines flip so stale data never matches
    always @(negedge read_strobe_n) begin
        drive = {~pat, pat};
        colCnt = (colCnt == 10'h20f) ? 10'h000 : colCnt + 10'h001;
    end
    always @(posedge read_strobe_n) drive = ~drive;
    // Busy time counts down in controller cycles; nonblocking so the controller samples it race free
    always @(posedge mclk) if (busyCnt > 0) busyCnt <= busyCnt - 1;
endmodule // nand_dev_model

// ==== test/nand_host_bench.sv ====
// Self-checking bench for the NAND host controller
`timescale 1ns/100ps
`include "nand_host_defs.vh"
module nand_host_bench;
    reg mclk, reset_n, opValid, opHalf, wrValid, holdBusy;
    reg [3:0] opCode;
    reg [7:0] opColumn, busyLen;
    reg [15:0] opRow, wrData;
    reg [9:0] opCount;
    reg [31:0] seed;
    wire opReady, wrReady, rdValid_q, opDone_q, opError_q, busyView_q, chipSelect_n_q, cmdLatch_q, addrLatch_q;
    wire write_strobe_n_q, read_strobe_n_q, ioOe_q, readyBusy_n;
    wire [15:0] rdData_q, ioOut_q, ioIn, devIo;
    integer bad_count, checks_done, i;
    logic [7:0] rdQ[$], wrQ[$];
    // ========================================
    // Controller, part and the shared data lines
    assign ioIn = ioOe_q ? ioOut_q : devIo;
    nand_host #(.WIDE(0)) dut (.mclk(mclk), .reset_n(reset_n), .opValid(opValid), .opReady(opReady),
        .opCode(opCode), .opColumn(opColumn), .opRow(opRow), .opCount(opCount), .opHalf(opHalf), .wrData(wrData),
        .wrValid(wrValid), .wrReady(wrReady), .rdData_q(rdData_q), .rdValid_q(rdValid_q), .opDone_q(opDone_q),
        .opError_q(opError_q), .busyView_q(busyView_q), .chipSelect_n_q(chipSelect_n_q), .cmdLatch_q(cmdLatch_q),
        .addrLatch_q(addrLatch_q), .write_strobe_n_q(write_strobe_n_q), .read_strobe_n_q(read_strobe_n_q),
        .ioOut_q(ioOut_q), .ioOe_q(ioOe_q), .ioIn(ioIn), .readyBusy_n(readyBusy_n));
    nand_dev_model dev (.mclk(mclk), .chipSelect_n(chipSelect_n_q), .cmdLatch(cmdLatch_q), .addrLatch(addrLatch_q),
        .writeStrobe_n(write_strobe_n_q), .read_strobe_n(read_strobe_n_q), .ioBus(ioIn), .holdBusy(holdBusy),
        .busyLen(busyLen), .ioDrive(devIo), .readyBusy_n(readyBusy_n));
    // ========================================
    // Expectation helpers
    function [31:0] xs(input [31:0] x);
        reg [31:0] y;
        begin
            y = x ^ (x << 13);
            y = y ^ (y >> 17);
            xs = y ^ (y << 5);
        end
    endfunction
    // Setup and confirm codes; a zero second byte means a single cycle command
    function [15:0] expCmd(input [3:0] op, input h);
        case (op)
            0: expCmd = {7'h00, h, 8'h00};
            1: expCmd = 16'h5000;
            2: expCmd = 16'h9000;
            3: expCmd = 16'hFF00;
            4: expCmd = 16'h8010;
            5: expCmd = 16'h008A;
            6: expCmd = 16'h60D0;
            7: expCmd = 16'h7000;
            8: expCmd = 16'h2A00;
            9: expCmd = 16'h2324;
            10: expCmd = 16'h2C00;
            default: expCmd = 16'h7A00;
        endcase
    endfunction
    function integer addrNum(input [3:0] op);
        addrNum = (op < 2 || op == 4 || op == 5) ? 3 : (op == 2) ? 1 : (op == 6 || op == 9 || op == 11) ? 2 : 0;
    endfunction
    task check(input [15:0] seen, input [15:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", checks_done, bad_count);
            if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    // One operation: request, wait for its end, compare what the part saw
    task run_op(input [3:0] op, input [7:0] c, input [15:0] r, input h, input refuse);
        integer w, n, k;
        reg [15:0] ec;
        begin
            dev.cmdQ.delete();
            dev.addrQ.delete();
            dev.datQ.delete();
            rdQ.delete();
            wrQ.delete();
            ec = expCmd(op, h);
            n = refuse ? 0 : addrNum(op);
            opCode <= op;
            opColumn <= c;
            opRow <= r;
            opHalf <= h;
            opValid <= 1'b1;
            @(posedge mclk);
            opValid <= 1'b0;
            w = 0;
            while (opDone_q !== 1'b1 && opError_q !== 1'b1 && w < 2000) begin
                @(posedge mclk);
                w = w + 1;
            end
            if (w >= 2000) bad_count = bad_count + 1; // Hung operation counts as a mismatch
            check(opError_q, refuse);
            check(dev.cmdQ.size(), refuse ? 0 : (ec[7:0] != 8'h00 ? 2 : 1));
            if (!refuse) check(dev.cmdQ[0], ec[15:8]);
            if (!refuse && ec[7:0] != 8'h00) check(dev.cmdQ[1], ec[7:0]);
            check(dev.addrQ.size(), n);
            for (k = 0; k < n; k = k + 1) check(dev.addrQ[k], n == 2 ? r[8 * k +: 8] :
                (k == 0 ? c : r[8 * (k - 1) +: 8]));
            if (!refuse && op < 3) check(rdQ.size(), 3);
            for (k = 0; k < 3 && op < 3 && !refuse; k = k + 1) check(rdQ[k], (c + k) ^ ((op == 0 && h) ? 8'h80 : 8'h00));
            if (op == 4) check(dev.datQ.size(), 3);
            for (k = 0; k < 3 && op == 4; k = k + 1) check(dev.datQ[k], wrQ[k]);
            $display("test op %0h finished", op);
        end
    endtask
    // Data words handed over and read words returned
    always @(posedge mclk) begin
        if (wrValid && wrReady === 1'b1) begin
            wrQ.push_back(wrData[7:0]);
            wrData <= {8'h00, seed[15:8] ^ wrData[7:0] ^ 8'h5b};
        end
        if (rdValid_q === 1'b1) rdQ.push_back(rdData_q[7:0]);
    end
    // ========================================
    // Clock, watchdog and main sequence
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Twenty-six operations of under two hundred cycles each fit well inside this span
    initial begin
        #300_000;
        bad_count = bad_count + 1;
        wrap_up;
    end
    initial begin
        {reset_n, opValid, opHalf, holdBusy, opCode, opColumn, opRow} = 0;
        {wrValid, wrData, opCount, busyLen} = {1'b1, 16'h00a5, 10'h003, 8'h10};
        {seed, bad_count, checks_done} = {32'h0000_da0d, 32'h0000_0000, 32'h0000_0000};
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        // Every operation twice, busy time varied from prompt to slow
        for (i = 0; i < 24; i = i + 1) begin
            seed = xs(seed);
            busyLen <= 8'h08 + {2'b00, seed[29:24]};
            run_op(4'(i % 12), seed[7:0] % 8'd200, seed[23:8], seed[31], 1'b0);
        end
        run_op(4'hC, 8'h00, 16'h0000, 1'b0, 1'b1);
        holdBusy <= 1'b1;
        repeat (6) @(posedge mclk);
        run_op(`OP_ERASE, 8'h10, 16'h0101, 1'b0, 1'b1);
        holdBusy <= 1'b0;
        wrap_up;
    end
endmodule // nand_host_bench
